// ### verilog/drive_regs_consts.svh
// Register offsets, field positions and reset values for the drive register bank.
// Assumes byte addressing on a 32-bit APB; each register is one aligned word.
`ifndef DRIVE_REGS_CONSTS_SVH
`define DRIVE_REGS_CONSTS_SVH

// Register indices (printed numbers are not all multiples of four)
`define IDX_BCAST_OP       16'h0001
`define IDX_BCAST_SPEED    16'h0002
`define IDX_STATUS_FLAGS   16'h002C
`define IDX_OUT_CONTACT    16'h002D
`define IDX_DC_BUS         16'h0031
`define IDX_PID_FB         16'h0038
`define IDX_PID_IN         16'h0039
`define IDX_PID_OUT        16'h003A
`define IDX_CPU_REV        16'h003B
`define IDX_FLASH_REV      16'h003C
`define IDX_LINK_ERR       16'h003D
`define IDX_RATED_POWER    16'h003E
`define IDX_CTRL_METHOD    16'h003F
// Own control register: enables that let the broadcast word drive inputs 5..7
`define IDX_LOCAL_CTRL     16'h0040

// Operation word field positions
`define OP_RUN_BIT         0
`define OP_REV_BIT         1
`define OP_EXTERR_BIT      4
`define OP_ERRRST_BIT      5
`define OP_IN5_BIT         12
`define OP_IN6_BIT         13
`define OP_IN7_BIT         14

// Status flag positions
`define ST_RUN_BIT         0
`define ST_FDET1_BIT       4
`define ST_FDET2_BIT       5
`define ST_UV_BIT          7
`define ST_BB_BIT          8
`define ST_FREF_SRC_BIT    9
`define ST_RUN_SRC_BIT     10
`define ST_ERR_BIT         14
`define ST_TMO_BIT         15

// Link error detail mask: bits 0,1,3,4,5
`define LINK_ERR_MASK      16'h003B

// Reset values
`define RST_WORD16         16'h0000
`endif

// ### verilog/drive_regs_pkg.sv
// Types shared by the drive register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package drive_regs_pkg;
  typedef logic [15:0] reg16_t;  // One two-byte register value
endpackage

// ### verilog/drive_monitor_broadcast_regs.sv
// Register bank of a motor drive serial slave port, reached over APB.
// Assumes the drive core supplies monitor values synchronous to clk_sys.
`timescale 1ns/1ps
`include "drive_regs_consts.svh"

// Functional notes
// - Status bit 14 shows any error, incl. timeout
// - Status bit 15 shows serial link timeout
// - Status bit 7 shows low supply voltage
// - Status bit 8 shows output baseblock
// - Bits 9,10 zero when source is link
// - Bit 4 set when frequency at/below level
// - Bit 5 set when frequency at/above level
// - PID feedback unsigned, ten counts per percent
// - PID output signed, ten counts per percent
// - Link error details latch until error reset
// - Error reset accepted while drive runs
// - Operation bit 0 runs or stops drive
// - Operation bit 1 selects reverse rotation
// - Operation bit 4 raises external error
// - Operation bit 5 commands error reset
// - Undefined bits keep local signal values
// - Each register is a two-byte value
module drive_monitor_broadcast_regs #(
  parameter int unsigned ADDR_W = 12  // APB address width
) (
  input  wire logic                  clk_sys,            // 25 MHz system clock
  input  wire logic                  rst_n,              // Synchronous reset, active low
  input  wire logic                  psel,               // APB select
  input  wire logic                  penable,            // APB access phase
  input  wire logic                  pwrite,             // APB direction
  input  wire logic [ADDR_W-1:0]     paddr,              // APB byte address
  input  wire logic [31:0]           pwdata,             // APB write data
  input  wire logic [3:0]            pstrb,              // APB byte strobes
  output logic                       pready,             // APB ready
  output logic [31:0]                prdata,             // APB read data
  output logic                       pslverr,            // APB error
  input  wire logic                  running,            // Drive is running
  input  wire logic                  zero_speed,         // Output at zero speed
  input  wire logic                  freq_match,         // Frequency matched
  input  wire logic                  user_speed_match,   // User speed matched
  input  wire logic [15:0]           output_freq,        // Output frequency
  input  wire logic [15:0]           freq_detect_level,  // Detection level
  input  wire logic                  startup_done,       // Startup complete
  input  wire logic                  undervoltage_alarm, // Low supply detected
  input  wire logic                  baseblock,          // Output baseblock
  input  wire logic                  overtorque,         // Overtorque detected
  input  wire logic                  freq_ref_lost,      // Reference lost
  input  wire logic                  retrying,           // Error retry active
  input  wire logic                  drive_fault,        // Any other drive error
  input  wire logic                  link_timeout,       // Link timed out
  input  wire logic                  freq_ref_from_link, // Reference source is link
  input  wire logic                  run_cmd_from_link,  // Run source is link
  input  wire logic                  relay_output_main,  // Relay output state
  input  wire logic                  open_collector_output_one, // Output 1 state
  input  wire logic                  open_collector_output_two, // Output 2 state
  input  wire logic [15:0]           dc_bus_volts,       // DC bus voltage
  input  wire logic [15:0]           pid_feedback,       // Unsigned, 10 per percent
  input  wire logic [15:0]           pid_input,          // Signed, 10 per percent
  input  wire logic [15:0]           pid_output,         // Signed, 10 per percent
  input  wire logic [15:0]           cpu_sw_rev,         // Main CPU revision
  input  wire logic [15:0]           flash_sw_rev,       // Flash revision
  input  wire logic [15:0]           rated_power,        // Rated power setting
  input  wire logic [15:0]           control_method,     // Control method code
  input  wire logic [5:0]            link_err_event,     // One-cycle error events
  input  wire logic                  local_run,          // Local run command
  input  wire logic                  local_reverse,      // Local direction
  input  wire logic                  local_ext_error,    // Local external error
  input  wire logic                  local_err_reset,    // Local error reset
  input  wire logic                  remote_input_five,  // Local input five
  input  wire logic                  remote_input_six,   // Local input six
  input  wire logic                  remote_input_seven, // Local input seven
  output logic                       cmd_run,            // Effective run command
  output logic                       cmd_reverse,        // Effective direction
  output logic                       cmd_ext_error,      // Effective external error
  output logic                       cmd_err_reset,      // Error reset pulse
  output logic                       cmd_input_five,     // Effective input five
  output logic                       cmd_input_six,      // Effective input six
  output logic                       cmd_input_seven,    // Effective input seven
  output logic [15:0]                speed_reference     // Broadcast frequency reference
);

  // Bus access phases. ST_DONE marks the cycle in which pready stands, so a
  // master that keeps psel and penable up for that cycle is not taken twice.
  // The price is one wait state on every access.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DONE = 2'b10
  } apb_state_t;

  apb_state_t              state_q;        // Access handshake state
  drive_regs_pkg::reg16_t  op_word_q;      // Last broadcast operation word
  logic                    op_valid_q;     // A broadcast word has been received
  drive_regs_pkg::reg16_t  link_err_q;     // Latched link error details
  logic [2:0]              local_ctrl_q;   // Enables for broadcast inputs 5..7
  drive_regs_pkg::reg16_t  rd_word;        // Combinational read mux
  logic                    rd_hit;         // Read address decoded
  logic                    wr_hit;         // Write address decoded
  logic                    access;         // Access phase this cycle
  logic                    err_reset_req;  // Any error reset source
  logic [15:0]             idx;            // Register index from byte address

  // Byte address to register index; low two bits must be zero
  // Unaligned addresses alias onto the word below; masters must not use them.
  // One function keeps the read and write decode on the same mapping.
  function automatic logic [15:0] addr_index(input logic [ADDR_W-1:0] a);
    logic [15:0] w;
    w = 16'h0000;
    w[ADDR_W-3:0] = a[ADDR_W-1:2];
    return w;
  endfunction

  assign idx    = addr_index(paddr);
  assign access = psel && penable && (state_q == ST_IDLE);

  // Read decode of the monitor range; no read changes state
  // Status bits come from live inputs, so a read shows the level seen at the
  // access edge rather than a snapshot taken earlier.
  // Frequency detection compares unsigned counts; both flags set on equality.
  always_comb begin
    rd_word = `RST_WORD16;
    rd_hit  = 1'b1;
    unique case (idx)
      `IDX_STATUS_FLAGS: begin
        rd_word[`ST_RUN_BIT]      = running;
        rd_word[1]                = zero_speed;
        rd_word[2]                = freq_match;
        rd_word[3]                = user_speed_match;
        rd_word[`ST_FDET1_BIT]    = (output_freq <= freq_detect_level);
        rd_word[`ST_FDET2_BIT]    = (output_freq >= freq_detect_level);
        rd_word[6]                = startup_done;
        rd_word[`ST_UV_BIT]       = undervoltage_alarm;
        rd_word[`ST_BB_BIT]       = baseblock;
        rd_word[`ST_FREF_SRC_BIT] = !freq_ref_from_link;
        rd_word[`ST_RUN_SRC_BIT]  = !run_cmd_from_link;
        rd_word[11]               = overtorque;
        rd_word[12]               = freq_ref_lost;
        rd_word[13]               = retrying;
        rd_word[`ST_ERR_BIT]      = drive_fault || link_timeout;
        rd_word[`ST_TMO_BIT]      = link_timeout;
      end
      `IDX_OUT_CONTACT: begin
        rd_word[0] = relay_output_main;
        rd_word[1] = open_collector_output_one;
        rd_word[2] = open_collector_output_two;
      end
      `IDX_DC_BUS:      rd_word = dc_bus_volts;
      `IDX_PID_FB:      rd_word = pid_feedback;
      `IDX_PID_IN:      rd_word = pid_input;
      `IDX_PID_OUT:     rd_word = pid_output;
      `IDX_CPU_REV:     rd_word = cpu_sw_rev;
      `IDX_FLASH_REV:   rd_word = flash_sw_rev;
      `IDX_LINK_ERR:    rd_word = link_err_q;
      `IDX_RATED_POWER: rd_word = rated_power;
      `IDX_CTRL_METHOD: rd_word = control_method;
      `IDX_LOCAL_CTRL:  rd_word = {13'h0000, local_ctrl_q};
      // Broadcast words are write-only; unused numbers read zero
      default:          rd_hit = (idx >= 16'h002E) && (idx <= 16'h0037);
    endcase
  end

  // Write decode covers the broadcast pair and the local control word
  assign wr_hit = (idx == `IDX_BCAST_OP) || (idx == `IDX_BCAST_SPEED) ||
                  (idx == `IDX_LOCAL_CTRL);

  // APB handshake: access taken at the first enable edge, answered one cycle later
  // pslverr flags unmapped numbers and reads of the write-only broadcast pair.
  // prdata keeps its last value outside the pready cycle; only that cycle counts.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (access) begin
      state_q <= ST_DONE;
      pready  <= 1'b1;
      // Upper half always zero: registers are two bytes wide
      prdata  <= pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
      pslverr <= pwrite ? !wr_hit : !rd_hit;
    end else begin
      state_q <= ST_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Broadcast operation word; partial strobes update only enabled bytes
  // op_valid_q keeps run and direction on the local source until the first
  // broadcast word arrives, so power-up behaviour does not depend on the link.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      op_word_q  <= `RST_WORD16;
      op_valid_q <= 1'b0;
    end else if (access && pwrite && idx == `IDX_BCAST_OP) begin
      if (pstrb[0]) op_word_q[7:0]  <= pwdata[7:0];
      if (pstrb[1]) op_word_q[15:8] <= pwdata[15:8];
      op_valid_q <= 1'b1;
    end
  end

  // Broadcast speed reference drives the output directly
  // The value is passed on unscaled; the drive core applies its own units.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      speed_reference <= `RST_WORD16;
    end else if (access && pwrite && idx == `IDX_BCAST_SPEED) begin
      if (pstrb[0]) speed_reference[7:0]  <= pwdata[7:0];
      if (pstrb[1]) speed_reference[15:8] <= pwdata[15:8];
    end
  end

  // Local control word: which of inputs 5..7 the broadcast word overrides
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      local_ctrl_q <= 3'h0;
    end else if (access && pwrite && idx == `IDX_LOCAL_CTRL && pstrb[0]) begin
      local_ctrl_q <= pwdata[2:0];
    end
  end

  // Error reset comes from the broadcast word pulse or the local source
  assign err_reset_req = (access && pwrite && idx == `IDX_BCAST_OP && pstrb[0] &&
                          pwdata[`OP_ERRRST_BIT]) || local_err_reset;

  // Link error details latch; no dependence on run state for clearing
  // Bit 2 is masked so a stray event on it never shows in the word.
  // A clear and an event in one cycle keep the event: losing it hides a fault.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      link_err_q <= `RST_WORD16;
    end else begin
      // New events win over a clear in the same cycle
      link_err_q <= ((err_reset_req ? `RST_WORD16 : link_err_q) |
                    {10'h000, link_err_event}) & `LINK_ERR_MASK;
    end
  end

  // Effective operation signals; broadcast only where it defines a bit
  // Every command is registered so each output comes from a flip-flop; this
  // adds one cycle between a broadcast write and its effect on the drive.
  // A held local error reset holds cmd_err_reset high throughout; the core sees one reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd_run         <= 1'b0;
      cmd_reverse     <= 1'b0;
      cmd_ext_error   <= 1'b0;
      cmd_err_reset   <= 1'b0;
      cmd_input_five  <= 1'b0;
      cmd_input_six   <= 1'b0;
      cmd_input_seven <= 1'b0;
    end else begin
      // Run and direction follow the link only when it is the run source
      cmd_run     <= (op_valid_q && run_cmd_from_link) ?
                     op_word_q[`OP_RUN_BIT] : local_run;
      cmd_reverse <= (op_valid_q && run_cmd_from_link) ?
                     op_word_q[`OP_REV_BIT] : local_reverse;
      cmd_ext_error <= (op_valid_q && op_word_q[`OP_EXTERR_BIT]) ||
                       local_ext_error;
      cmd_err_reset <= err_reset_req;
      // Undefined or disabled bits keep following the local inputs
      cmd_input_five  <= (op_valid_q && local_ctrl_q[0]) ?
                         op_word_q[`OP_IN5_BIT] : remote_input_five;
      cmd_input_six   <= (op_valid_q && local_ctrl_q[1]) ?
                         op_word_q[`OP_IN6_BIT] : remote_input_six;
      cmd_input_seven <= (op_valid_q && local_ctrl_q[2]) ?
                         op_word_q[`OP_IN7_BIT] : remote_input_seven;
    end
  end

endmodule

// ### dv/apb_master.sv
// APB master model standing in for the link controller.
// Assumes the bench cuts short any wait that hangs.
`timescale 1ns/1ps
module apb_master (
  input  wire logic        clk_sys,  // System clock
  input  wire logic        pready,   // Slave ready
  input  wire logic [31:0] prdata,   // Read data
  input  wire logic        pslverr,  // Slave error
  output logic             psel,     // Select
  output logic             penable,  // Access phase
  output logic             pwrite,   // Direction
  output logic [11:0]      paddr,    // Byte address
  output logic [31:0]      pwdata,   // Write data
  output logic [3:0]       pstrb     // Byte strobes
);
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  // Request held until pready is seen high at an edge, then released
  task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= {2'b00, w, w};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ### dv/drive_regs_props.sv
// Port assertions for the drive register bank.
// Bound to every bank instance; watches its ports only.
`timescale 1ns/1ps
module drive_regs_props #(
  parameter int unsigned ADDR_W = 12  // Address width
) (
  input wire logic              clk_sys,            // Clock
  input wire logic              rst_n,              // Reset, active low
  input wire logic              psel,               // Select
  input wire logic              penable,            // Access phase
  input wire logic              pwrite,             // Direction
  input wire logic [ADDR_W-1:0] paddr,              // Address
  input wire logic [31:0]       pwdata,             // Write data
  input wire logic              pready,             // Ready
  input wire logic [31:0]       prdata,             // Read data
  input wire logic              pslverr,            // Error
  input wire logic              undervoltage_alarm, // Low supply
  input wire logic              baseblock,          // Output blocked
  input wire logic              link_timeout,       // Link timed out
  input wire logic              freq_ref_from_link, // Reference from link
  input wire logic              run_cmd_from_link,  // Run from link
  input wire logic              cmd_err_reset,      // Error reset pulse
  input wire logic [15:0]       speed_reference     // Frequency reference
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Good reads, and status reads where the flag relations show
  wire rd_ok = pready && !pwrite && !pslverr;
  wire st_rd = rd_ok && paddr == 12'h0B0;
  // Access cycle of a broadcast write asking for an error reset
  wire rst_wr = psel && penable && pwrite && !pready && paddr == 12'h004 && pwdata[5];
  chk_one_wait: assert property ($rose(penable) && psel |=> pready ##1 !pready)
    else $error("ready not after one wait state");
  chk_upper_zero: assert property (rd_ok |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  chk_timeout_bits: assert property (
    st_rd |-> prdata[15] == link_timeout && (prdata[14] || !link_timeout))
    else $error("timeout flags wrong");
  chk_uv_block: assert property (st_rd |-> prdata[8:7] == {baseblock, undervoltage_alarm})
    else $error("supply or block flag wrong");
  chk_source_bits: assert property (
    st_rd |-> prdata[10:9] == ~{run_cmd_from_link, freq_ref_from_link})
    else $error("source flags wrong");
  chk_err_reset: assert property (rst_wr |-> ##[1:3] cmd_err_reset)
    else $error("no error reset pulse");
  chk_unused_zero: assert property (
    pready && !pwrite && paddr >= 12'h0C8 && paddr <= 12'h0DC |-> !pslverr && prdata == 32'h0)
    else $error("unused place not zero");
  chk_bcast_noread: assert property (
    pready && !pwrite && (paddr == 12'h004 || paddr == 12'h008) |-> pslverr)
    else $error("broadcast read not refused");
  chk_speed_ref: assert property (
    pready && pwrite && !pslverr && paddr == 12'h008 |=> speed_reference == $past(pwdata[15:0]))
    else $error("speed reference not taken");
  cover property (st_rd && link_timeout);
  cover property (rst_wr);
  cover property (pready && pslverr);
endmodule
bind drive_monitor_broadcast_regs drive_regs_props #(.ADDR_W(ADDR_W)) chk_u (.*);

// ### dv/drive_monitor_broadcast_regs_tb.sv
// Self-checking bench for the drive register bank.
// Assumes the APB master model and the bound checker compile with it.
`timescale 1ns/1ps
module drive_monitor_broadcast_regs_tb;
  logic         clk_sys = 1'b0;  // 25 MHz clock
  logic         rst_n = 1'b0;    // Synchronous reset, active low
  logic [16:0]  mon = 17'h00000; // One bit per drive state, 17 in all, fanned out below
  logic [6:0]   loc = 7'h00;     // Local operation inputs
  int           rst_pulses = 0;  // Error reset pulses counted
  int           num_errors = 0;
  int           samples_checked = 0;
  logic         psel, penable, pwrite, pready, pslverr, cmd_run, cmd_reverse, cmd_ext_error;
  logic         cmd_err_reset, cmd_input_five, cmd_input_six, cmd_input_seven, running;
  logic         zero_speed, freq_match, user_speed_match, startup_done, baseblock, retrying;
  logic         undervoltage_alarm, overtorque, freq_ref_lost, drive_fault, link_timeout;
  logic         freq_ref_from_link, run_cmd_from_link, relay_output_main, local_run;
  logic         open_collector_output_one, open_collector_output_two, local_reverse;
  logic         local_ext_error, local_err_reset, remote_input_five, remote_input_six;
  logic         remote_input_seven;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata;
  logic [3:0]   pstrb;
  logic [5:0]   link_err_event = 6'h00;
  logic [15:0]  output_freq = 16'h0000, freq_detect_level = 16'h00C8, speed_reference;
  logic [15:0]  dc_bus_volts, pid_feedback, pid_input, pid_output, cpu_sw_rev;
  logic [15:0]  flash_sw_rev, rated_power, control_method;
  // Monitor words in address order; distinct so a mixed-up address shows
  logic [127:0] mv = 128'h0136_03E8_FC18_FF9C_0101_0203_0005_0002;
  logic [11:0]  ma [8] = '{12'h0C4, 12'h0E0, 12'h0E4, 12'h0E8,
                          12'h0EC, 12'h0F0, 12'h0F8, 12'h0FC};
  assign {run_cmd_from_link, freq_ref_from_link, link_timeout, drive_fault, retrying,
          freq_ref_lost, overtorque, baseblock, undervoltage_alarm, startup_done,
          user_speed_match, freq_match, zero_speed, running, open_collector_output_two,
          open_collector_output_one, relay_output_main} = mon;
  assign {remote_input_seven, remote_input_six, remote_input_five, local_err_reset,
          local_ext_error, local_reverse, local_run} = loc;
  assign {dc_bus_volts, pid_feedback, pid_input, pid_output, cpu_sw_rev, flash_sw_rev,
          rated_power, control_method} = mv;
  always #20 clk_sys = ~clk_sys;
  // The pulse lasts one cycle, so it is caught here rather than polled
  always @(posedge clk_sys) if (cmd_err_reset === 1'b1) rst_pulses <= rst_pulses + 1;
  drive_monitor_broadcast_regs #(.ADDR_W(12)) dut_u (.*);
  apb_master apb_u (.*);
  // Hang guard, well above the few hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Read; the error flag is always compared, the data only when no error
  task automatic rd(input logic [11:0] a, input logic [15:0] exp, input logic err);
    logic [31:0] r;
    logic        e;
    apb_u.xfer(1'b0, a, 16'h0000, r, e);
    check({e, err ? 31'h0 : r[30:0]}, {err, 15'h0000, err ? 16'h0000 : exp});
  endtask
  // Write, then let the command outputs settle
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic        e;
    apb_u.xfer(1'b1, a, d, r, e);
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic set_mon(input logic [16:0] v, input logic [15:0] f, input logic [6:0] l);
    @(posedge clk_sys);
    mon <= v;
    output_freq <= f;
    loc <= l;
    mv <= mv ^ {8{16'h1111}};
    #1;
  endtask
  task automatic t_status();
    logic [16:0] v [3];
    v = '{17'h1AAAA, 17'h05555, 17'h0FF0F};
    for (int i = 0; i < 3; i++) begin
      set_mon(v[i], 16'(100 * i + 100), 7'h00);
      rd(12'h0B0, {link_timeout, drive_fault | link_timeout, retrying, freq_ref_lost,
         overtorque, ~run_cmd_from_link, ~freq_ref_from_link, baseblock, undervoltage_alarm,
         startup_done, output_freq >= freq_detect_level, output_freq <= freq_detect_level,
         user_speed_match, freq_match, zero_speed, running}, 1'b0);
      rd(12'h0B4, {13'h0000, mon[2:0]}, 1'b0);
      for (int k = 0; k < 8; k++)
        rd(ma[k], mv[127 - 16 * k -: 16], 1'b0);
    end
    $display("test status done");
  endtask
  task automatic t_link_err();
    int n;
    set_mon(17'h00008, 16'h0000, 7'h00);
    @(posedge clk_sys);
    link_err_event <= 6'h3F;
    @(posedge clk_sys);
    link_err_event <= 6'h00;
    rd(12'h0F4, 16'h003B, 1'b0);
    rd(12'h0F4, 16'h003B, 1'b0);
    n = rst_pulses;
    wr(12'h004, 16'h0020);
    check(32'(rst_pulses - n), 32'h1);
    rd(12'h0F4, 16'h0000, 1'b0);
    // Local reset and a new event in one cycle: the event must stay latched
    @(posedge clk_sys);
    loc <= 7'h08;
    link_err_event <= 6'h01;
    @(posedge clk_sys);
    loc <= 7'h00;
    link_err_event <= 6'h00;
    rd(12'h0F4, 16'h0001, 1'b0);
    check(32'(rst_pulses - n), 32'h2);
    $display("test link error done");
  endtask
  task automatic t_bcast();
    set_mon(17'h10000, 16'h0000, 7'h00);
    wr(12'h004, 16'h0003);
    check({30'h0, cmd_run, cmd_reverse}, 32'h3);
    wr(12'h004, 16'h0010);
    check({29'h0, cmd_run, cmd_reverse, cmd_ext_error}, 32'h1);
    wr(12'h008, 16'h1770);
    check({16'h0000, speed_reference}, 32'h1770);
    set_mon(17'h00000, 16'h0000, 7'h71);
    wr(12'h004, 16'h0000);
    check({28'h0, cmd_input_five, cmd_input_six, cmd_input_seven, cmd_run}, 32'hF);
    // Enable the broadcast inputs; they now follow the word, run stays local
    wr(12'h100, 16'h0007);
    rd(12'h100, 16'h0007, 1'b0);
    set_mon(17'h00000, 16'h0000, 7'h00);
    wr(12'h004, 16'h7000);
    check({28'h0, cmd_input_five, cmd_input_six, cmd_input_seven, cmd_run}, 32'hE);
    rd(12'h004, 16'h0000, 1'b1);
    rd(12'h200, 16'h0000, 1'b1);
    rd(12'h0C8, 16'h0000, 1'b0);
    rd(12'h0DC, 16'h0000, 1'b0);
    $display("test broadcast done");
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    check({12'h000, cmd_run, cmd_reverse, cmd_ext_error, cmd_err_reset, speed_reference}, 32'h0);
    $display("test reset done");
    t_status();
    t_link_err();
    t_bcast();
    print_verdict();
  end
endmodule
